// File: design/dpll_ctrl_map.svh
// Register map, field positions, reset values and timing figures
// Assumes a 200 MHz core clock and a 32-bit APB register bus
`ifndef DPLL_CTRL_MAP_SVH
`define DPLL_CTRL_MAP_SVH

`define CORE_CLK_MHZ       200
`define REF_WIN_US         1000
`define ADDR_PLL_CTRL      12'h000
`define ADDR_REF_CHG_CTRL  12'h004
`define ADDR_REF_FREQ_PROG 12'h008
`define ADDR_OUT_SEL       12'h00C
`define ADDR_REF_CHG_STAT  12'h010
`define ADDR_REF_FREQ_STAT 12'h014
`define CTRL_IRM_BIT       0
`define CTRL_RFPE_BIT      1
`define CTRL_MODE_LSB      2
`define RCC_PMS_LSB        2
`define OSEL_T1E1_BIT      2
`define OSEL_FP3_LSB       3
`define PLL_CTRL_RST       4'hC
`define RCC_RST            5'h00
`define RFP_RST            12'h000
`define OSEL_RST           5'h00
`define PMS_PREFERRED      3'h1
`define FREQ_CODES         7
`define REF_TOL_SHIFT      6
`define PULL_IN_PPM        260
`define JITTER_UI          1023
`define LOOP_CORNER_DHZ    152
`define LOOP_SHIFT         3
`define PHASE_SHIFT        4
`define PPM_SCALE          1000000
`define FRAME_INC          40'h00_029F_16B1
`define FRAME_PPM_STEP     40'h00_0000_002C
`define T1_INC             40'h00_01F9_ECBC
`define T1_PPM_STEP        40'h00_0000_0021
`define E1_INC             40'h00_029F_16B1
`define E1_PPM_STEP        40'h00_0000_002C
`define SONET_INC          40'h00_18E2_9F65
`define SONET_PPM_STEP     40'h00_0000_01A1
`define CK_BIT_32M         27
`define CK_BIT_16M         28
`define CK_BIT_8M          29
`define CK_BIT_4M          30
`define FP_A_NS            244
`define FP_B_NS            122
`define FP_C_NS            61
`define FP_D_NS            30
`define FP_SONET_NS        51
`define NS_CYC(ns)         (((ns) * `CORE_CLK_MHZ + 999) / 1000)

`endif

// File: design/dpll_ctrl_pkg.sv
// Types shared by the reference and mode controller
// Assumes nothing beyond the map header for figures
package dpll_ctrl_pkg;
  typedef enum logic [1:0] {
    mode_forced, mode_holdover, mode_freerun, mode_auto
  } pll_mode_t;
  typedef enum logic [1:0] {
    st_off, st_track, st_hold, st_free
  } pll_state_t;
  typedef logic [2:0] freq_code_t;
endpackage

// File: design/dpll_mode_ctrl.sv
// Mode, reference selection and output synthesis of the embedded PLL
// Assumes an APB master on core_clk and four asynchronous reference pins
`timescale 1ns/1ps
`include "dpll_ctrl_map.svh"

module dpll_mode_ctrl
  import dpll_ctrl_pkg::*;
#(
  parameter int unsigned WIN_CYCLES = `REF_WIN_US * `CORE_CLK_MHZ,
  parameter int unsigned HOLD_DEPTH = 4
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  sync_reference_inputs,
  output logic             clk_out_a,
  output logic             clk_out_b,
  output logic             clk_out_c,
  output logic             clk_out_selectable,
  output logic             clk_out_t1_e1,
  output logic             clk_out_sonet,
  output logic             frame_pulse_out_a,
  output logic             frame_pulse_out_b,
  output logic             frame_pulse_out_c,
  output logic             frame_pulse_out_selectable,
  output logic             frame_pulse_out_sonet
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] nominal_count(input freq_code_t c);
    logic [63:0] khz;
    case (c)
      3'h1:    khz = 64'd8;
      3'h2:    khz = 64'd1544;
      3'h3:    khz = 64'd2048;
      3'h4:    khz = 64'd4096;
      3'h5:    khz = 64'd8192;
      3'h6:    khz = 64'd16384;
      3'h7:    khz = 64'd19440;
      default: khz = 64'd0;
    endcase
    khz = khz * 64'(WIN_CYCLES) / 64'(`CORE_CLK_MHZ * 1000);
    nominal_count = khz[31:0];
  endfunction

  function automatic freq_code_t detect_code(input logic [15:0] cnt);
    logic [31:0] nom;
    logic [31:0] tol;
    detect_code = 3'h0;
    for (int c = 1; c <= `FREQ_CODES; c++) begin
      nom = nominal_count(3'(c));
      tol = (nom >> `REF_TOL_SHIFT) + 32'd1;
      // A window too short to hold one period can never match
      if (nom != 32'd0 && {16'd0, cnt} + tol >= nom
          && {16'd0, cnt} <= nom + tol) begin
        detect_code = 3'(c);
      end
    end
  endfunction

  function automatic logic signed [31:0] to_ppm(
    input logic signed [31:0] ui,
    input logic        [31:0] nom
  );
    logic signed [63:0] p;
    logic signed [63:0] n;
    p = {{32{ui[31]}}, ui};
    n = {32'd0, nom};
    if (nom == 32'd0) begin
      p = 64'sd0;
    end else begin
      p = p * 64'sd`PPM_SCALE / n;
    end
    to_ppm = p[31:0];
  endfunction

  function automatic logic signed [31:0] sat(
    input logic signed [31:0] x,
    input logic signed [31:0] lim
  );
    if (x > lim) begin
      sat = lim;
    end else if (x < -lim) begin
      sat = -lim;
    end else begin
      sat = x;
    end
  endfunction

  function automatic logic [39:0] nco_inc(
    input logic        [39:0] base,
    input logic        [39:0] step,
    input logic signed [9:0]  adj
  );
    logic [39:0] a;
    a = {{30{adj[9]}}, adj};
    nco_inc = base + a * step;
  endfunction

  // ****************************************
  // Registers and APB slave
  // ****************************************
  logic [3:0]  pll_control_q;
  logic [4:0]  ref_change_ctrl_q;
  logic [11:0] ref_freq_prog_q;
  logic [4:0]  out_sel_q;
  logic [31:0] rd_val;
  logic        addr_hit;
  logic        addr_ro;
  logic        wr_en;
  pll_state_t  state_q;
  pll_state_t  state_d;
  logic [1:0]  active_ref_q;
  logic [1:0]  active_d;
  freq_code_t  freq_det_q [4];
  logic [3:0]  ref_ok_q;

  wire pll_mode_t mode  = pll_mode_t'(pll_control_q[`CTRL_MODE_LSB +: 2]);
  wire logic      irm   = pll_control_q[`CTRL_IRM_BIT];
  wire logic      rfpe  = pll_control_q[`CTRL_RFPE_BIT];
  wire logic [1:0] sel  = ref_change_ctrl_q[1:0];
  wire logic [2:0] pms  = ref_change_ctrl_q[`RCC_PMS_LSB +: 3];

  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    rd_val   = 32'h0000_0000;
    addr_hit = 1'b1;
    addr_ro  = 1'b0;
    case (paddr)
      `ADDR_PLL_CTRL:      rd_val = {28'd0, pll_control_q};
      `ADDR_REF_CHG_CTRL:  rd_val = {27'd0, ref_change_ctrl_q};
      `ADDR_REF_FREQ_PROG: rd_val = {20'd0, ref_freq_prog_q};
      `ADDR_OUT_SEL:       rd_val = {27'd0, out_sel_q};
      `ADDR_REF_CHG_STAT: begin
        addr_ro = 1'b1;
        rd_val  = {20'd0, ref_ok_q, state_q == st_off,
                   state_q == st_free, state_q == st_hold,
                   freq_det_q[active_ref_q], active_ref_q};
      end
      `ADDR_REF_FREQ_STAT: begin
        addr_ro = 1'b1;
        rd_val  = {20'd0, freq_det_q[3], freq_det_q[2],
                   freq_det_q[1], freq_det_q[0]};
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // No wait state: answer built during setup, shown in access phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & (~addr_hit | (pwrite & addr_ro));
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // Internal reset never touches these: they stay writable and keep values
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_control_q     <= `PLL_CTRL_RST;
      ref_change_ctrl_q <= `RCC_RST;
      ref_freq_prog_q   <= `RFP_RST;
      out_sel_q         <= `OSEL_RST;
    end else if (wr_en && !pslverr) begin
      case (paddr)
        `ADDR_PLL_CTRL:      pll_control_q     <= pwdata[3:0];
        `ADDR_REF_CHG_CTRL:  ref_change_ctrl_q <= pwdata[4:0];
        `ADDR_REF_FREQ_PROG: ref_freq_prog_q   <= pwdata[11:0];
        `ADDR_OUT_SEL:       out_sel_q         <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Reference measurement
  // ****************************************
  logic [3:0]  ref_s1_q;
  logic [3:0]  ref_s2_q;
  logic [3:0]  ref_s3_q;
  logic [31:0] win_cnt_q;
  logic [15:0] ref_cnt_q [4];
  freq_code_t  det_now [4];
  freq_code_t  eff_code [4];
  logic [3:0]  ok_now;
  wire logic   eval = (win_cnt_q == 32'(WIN_CYCLES - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_s1_q <= 4'h0;
      ref_s2_q <= 4'h0;
      ref_s3_q <= 4'h0;
    end else begin
      ref_s1_q <= sync_reference_inputs;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_q <= 32'd0;
      ref_ok_q  <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        ref_cnt_q[i]  <= 16'd0;
        freq_det_q[i] <= 3'h0;
      end
    end else begin
      win_cnt_q <= eval ? 32'd0 : win_cnt_q + 32'd1;
      if (eval) begin
        ref_ok_q <= ok_now;
      end
      for (int i = 0; i < 4; i++) begin
        if (eval) begin
          ref_cnt_q[i]  <= 16'd0;
          freq_det_q[i] <= det_now[i];
        end else if (ref_s2_q[i] && !ref_s3_q[i] && !(&ref_cnt_q[i])) begin
          ref_cnt_q[i] <= ref_cnt_q[i] + 16'd1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      det_now[i]  = detect_code(ref_cnt_q[i]);
      eff_code[i] = rfpe ? ref_freq_prog_q[3*i +: 3] : det_now[i];
      ok_now[i]   = (det_now[i] != 3'h0) && (det_now[i] == eff_code[i]);
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  wire logic [1:0] sel_next    = sel + 2'd1;
  wire logic [1:0] active_next = active_ref_q + 2'd1;
  logic [1:0] rr_idx;
  logic       rr_found;

  always_comb begin
    rr_idx   = 2'd0;
    rr_found = 1'b0;
    for (int i = 3; i >= 1; i--) begin
      if (ok_now[active_ref_q + 2'(i)]) begin
        rr_idx   = active_ref_q + 2'(i);
        rr_found = 1'b1;
      end
    end
  end

  always_comb begin
    state_d  = state_q;
    active_d = active_ref_q;
    if (irm) begin
      state_d = st_off;
    end else if (state_q == st_off) begin
      state_d = st_free;
    end else if (eval) begin
      case (mode)
        mode_forced: begin
          state_d  = st_track;
          active_d = sel;
        end
        mode_holdover: state_d = st_hold;
        mode_freerun:  state_d = st_free;
        mode_auto: begin
          state_d = st_hold;
          if (pms == `PMS_PREFERRED) begin
            if (ok_now[sel]) begin
              state_d  = st_track;
              active_d = sel;
            end else if (ok_now[sel_next]) begin
              state_d  = st_track;
              active_d = sel_next;
            end
          end else if (ok_now[active_ref_q]) begin
            state_d = st_track;
          end else if (rr_found) begin
            state_d  = st_track;
            active_d = rr_idx;
          end
        end
        default: state_d = st_free;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= st_off;
      active_ref_q <= 2'd0;
    end else begin
      state_q      <= state_d;
      active_ref_q <= active_d;
    end
  end

  // ****************************************
  // Loop filter and holdover memory
  // ****************************************
  logic signed [9:0]  freq_adj_q;
  logic signed [10:0] phase_ui_q;
  logic signed [9:0]  hold_mem_q [HOLD_DEPTH];
  logic signed [31:0] err_ui;
  logic signed [31:0] target;
  logic signed [31:0] adj_next;
  logic signed [31:0] phase_next;
  logic [31:0]        nom_act;
  wire logic signed [9:0] hold_oldest = hold_mem_q[HOLD_DEPTH-1];
  wire logic track_upd = eval && state_q == st_track && ok_now[active_ref_q];

  always_comb begin
    nom_act    = nominal_count(eff_code[active_ref_q]);
    err_ui     = $signed({16'd0, ref_cnt_q[active_ref_q]}) - $signed(nom_act);
    phase_next = sat(32'(phase_ui_q) + err_ui, `JITTER_UI);
    target     = sat(to_ppm(err_ui, nom_act)
                     + (to_ppm(phase_next, nom_act) >>> `PHASE_SHIFT),
                     `PULL_IN_PPM);
    // Shift sets a corner near 15.2 Hz at a 1 kHz window rate
    adj_next   = sat(32'(freq_adj_q)
                     + ((target - 32'(freq_adj_q)) >>> `LOOP_SHIFT),
                     `PULL_IN_PPM);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      freq_adj_q <= 10'sd0;
      phase_ui_q <= 11'sd0;
    end else if (state_q == st_off || state_q == st_free) begin
      freq_adj_q <= 10'sd0;
      phase_ui_q <= 11'sd0;
    end else if (state_d == st_hold && state_q != st_hold) begin
      freq_adj_q <= hold_oldest;
      phase_ui_q <= 11'sd0;
    end else if (track_upd) begin
      freq_adj_q <= adj_next[9:0];
      phase_ui_q <= phase_next[10:0];
    end
  end

  // Oldest entry predates the failure the monitor has yet to notice
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < HOLD_DEPTH; i++) begin
        hold_mem_q[i] <= 10'sd0;
      end
    end else if (eval && state_q == st_track) begin
      hold_mem_q[0] <= freq_adj_q;
      for (int i = 1; i < HOLD_DEPTH; i++) begin
        hold_mem_q[i] <= hold_mem_q[i-1];
      end
    end
  end

  // ****************************************
  // Output synthesis
  // ****************************************
  logic [39:0] frame_acc_q;
  logic [31:0] t1e1_acc_q;
  logic [31:0] sonet_acc_q;
  logic [7:0]  fp_age_q;
  logic [40:0] frame_sum;
  logic [7:0]  fp3_width;
  wire logic   t1_sel = out_sel_q[`OSEL_T1E1_BIT];
  wire logic [39:0] t1e1_inc = t1_sel
      ? nco_inc(`T1_INC, `T1_PPM_STEP, freq_adj_q)
      : nco_inc(`E1_INC, `E1_PPM_STEP, freq_adj_q);
  wire logic [39:0] sonet_inc =
      nco_inc(`SONET_INC, `SONET_PPM_STEP, freq_adj_q);

  assign frame_sum = {1'b0, frame_acc_q}
                   + {1'b0, nco_inc(`FRAME_INC, `FRAME_PPM_STEP, freq_adj_q)};

  always_comb begin
    case (out_sel_q[`OSEL_FP3_LSB +: 2])
      2'd0:    fp3_width = 8'(`NS_CYC(`FP_A_NS));
      2'd1:    fp3_width = 8'(`NS_CYC(`FP_B_NS));
      2'd2:    fp3_width = 8'(`NS_CYC(`FP_C_NS));
      default: fp3_width = 8'(`NS_CYC(`FP_D_NS));
    endcase
  end

  // All frame pulses start from one wrap so they stay aligned
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_acc_q <= 40'd0;
      t1e1_acc_q  <= 32'd0;
      sonet_acc_q <= 32'd0;
      fp_age_q    <= 8'hFF;
    end else if (state_q == st_off) begin
      frame_acc_q <= 40'd0;
      t1e1_acc_q  <= 32'd0;
      sonet_acc_q <= 32'd0;
      fp_age_q    <= 8'hFF;
    end else begin
      frame_acc_q <= frame_sum[39:0];
      t1e1_acc_q  <= t1e1_acc_q + t1e1_inc[31:0];
      sonet_acc_q <= sonet_acc_q + sonet_inc[31:0];
      if (frame_sum[40]) begin
        fp_age_q <= 8'd0;
      end else if (fp_age_q != 8'hFF) begin
        fp_age_q <= fp_age_q + 8'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_out_a                  <= 1'b0;
      clk_out_b                  <= 1'b0;
      clk_out_c                  <= 1'b0;
      clk_out_selectable         <= 1'b0;
      clk_out_t1_e1              <= 1'b0;
      clk_out_sonet              <= 1'b0;
      frame_pulse_out_a          <= 1'b0;
      frame_pulse_out_b          <= 1'b0;
      frame_pulse_out_c          <= 1'b0;
      frame_pulse_out_selectable <= 1'b0;
      frame_pulse_out_sonet      <= 1'b0;
    end else if (state_q == st_off) begin
      clk_out_a                  <= 1'b0;
      clk_out_b                  <= 1'b0;
      clk_out_c                  <= 1'b0;
      clk_out_selectable         <= 1'b0;
      clk_out_t1_e1              <= 1'b0;
      clk_out_sonet              <= 1'b0;
      frame_pulse_out_a          <= 1'b0;
      frame_pulse_out_b          <= 1'b0;
      frame_pulse_out_c          <= 1'b0;
      frame_pulse_out_selectable <= 1'b0;
      frame_pulse_out_sonet      <= 1'b0;
    end else begin
      clk_out_a     <= frame_acc_q[`CK_BIT_4M];
      clk_out_b     <= frame_acc_q[`CK_BIT_8M];
      clk_out_c     <= frame_acc_q[`CK_BIT_16M];
      clk_out_t1_e1 <= t1e1_acc_q[31];
      clk_out_sonet <= sonet_acc_q[31];
      case (out_sel_q[1:0])
        2'd0:    clk_out_selectable <= frame_acc_q[`CK_BIT_4M];
        2'd1:    clk_out_selectable <= frame_acc_q[`CK_BIT_8M];
        2'd2:    clk_out_selectable <= frame_acc_q[`CK_BIT_16M];
        default: clk_out_selectable <= frame_acc_q[`CK_BIT_32M];
      endcase
      frame_pulse_out_a <= fp_age_q < 8'(`NS_CYC(`FP_A_NS));
      frame_pulse_out_b <= fp_age_q < 8'(`NS_CYC(`FP_B_NS));
      frame_pulse_out_c <= fp_age_q < 8'(`NS_CYC(`FP_C_NS));
      frame_pulse_out_selectable <= fp_age_q < fp3_width;
      frame_pulse_out_sonet <= fp_age_q < 8'(`NS_CYC(`FP_SONET_NS));
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_irm_outputs_off: assert property (
    state_q == st_off |=> !clk_out_a && !clk_out_sonet && !frame_pulse_out_a)
    else $error("outputs active during internal reset");
  a_free_no_trim: assert property (
    state_q == st_free |=> freq_adj_q == 10'sd0)
    else $error("freerun frequency trimmed");
  a_hold_frozen: assert property (
    state_q == st_hold && $past(state_q) == st_hold |-> $stable(freq_adj_q))
    else $error("frequency moved in holdover");
  a_hold_restore: assert property (
    state_q == st_track && state_d == st_hold
      |=> freq_adj_q == $past(hold_oldest))
    else $error("holdover did not restore saved frequency");
  a_auto_two_states: assert property (
    eval && mode == mode_auto && !irm && state_q != st_off
      |=> state_q == st_track || state_q == st_hold)
    else $error("automatic mode left tracking and holdover");
  a_rr_next_ref: assert property (
    eval && mode == mode_auto && !irm && pms != `PMS_PREFERRED
      && state_q == st_track && !ok_now[active_ref_q] && ok_now[active_next]
      |=> active_ref_q == $past(active_next))
    else $error("round robin skipped next valid reference");
  a_pref_pair: assert property (
    eval && mode == mode_auto && !irm && pms == `PMS_PREFERRED
      && state_q != st_off
      |=> state_q == st_hold || active_ref_q == $past(sel)
          || active_ref_q == $past(sel_next))
    else $error("preferred mode used a third reference");
  a_forced_ref: assert property (
    eval && mode == mode_forced && !irm && state_q != st_off
      |=> state_q == st_track && active_ref_q == $past(sel))
    else $error("forced reference not taken");
  a_trim_range: assert property (
    freq_adj_q <= 10'sd260 && freq_adj_q >= -10'sd260)
    else $error("frequency trim beyond pull-in range");
  a_phase_range: assert property (
    phase_ui_q >= -11'sd1023)
    else $error("phase error beyond jitter range");
  a_fp_aligned: assert property (
    $rose(frame_pulse_out_a) |-> $rose(frame_pulse_out_b)
      && $rose(frame_pulse_out_c) && $rose(frame_pulse_out_sonet))
    else $error("frame pulses not aligned");
  a_hold_resume: assert property (
    eval && mode == mode_auto && !irm && pms != `PMS_PREFERRED
      && state_q == st_hold && (|ok_now)
      |=> state_q == st_track)
    else $error("holdover not left with a valid reference");

  c_auto_holdover: cover property (
    mode == mode_auto && state_q == st_track ##1 state_q == st_hold);
  c_auto_switch: cover property (
    mode == mode_auto && state_q == st_track && active_ref_q != active_d);
  c_irm_exit: cover property (state_q == st_off ##1 state_q == st_free);

endmodule

// File: verification/ref_src.sv
// Four reference clock sources, 2.048 MHz on even pins, 4.096 on odd
// Assumes the bench drives one enable per pin
`timescale 1ns/1ps
module ref_src (
  input  wire logic [3:0] en,
  output logic      [3:0] refs
);
  initial refs = 4'h0;
  // A lost reference stands low
  for (genvar i = 0; i < 4; i++) begin : g_src
    always #((i % 2) ? 122.07 : 244.14) refs[i] = en[i] & ~refs[i];
  end
endmodule

// File: verification/tb.sv
// Bench for the PLL mode controller: APB, status and frame pulses
// Assumes ref_src on the reference pins and a 2000-cycle window
`timescale 1ns/1ps
module tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_t;
  logic        core_clk = 0;
  logic        reset_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, sd, h, w = 0;
  logic        pready, pslverr, fs, fa_p;
  logic [9:0]  ck_p;
  wire  [9:0]  ck;
  int          nk[10];
  logic [3:0]  en = 4'h0;
  logic [3:0]  refs;
  int          errors = 0, n_compared = 0, seed = 32'h8d43_2a5f;
  exp_t        e, q[$];
  int          fq[$];
  always #2.5 core_clk = ~core_clk;
  ref_src src_u (.en(en), .refs(refs));
  dpll_mode_ctrl #(.WIN_CYCLES(2000)) dut_u (.core_clk(core_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_reference_inputs(refs), .clk_out_a(ck[0]),
    .clk_out_b(ck[1]), .clk_out_c(ck[2]), .clk_out_selectable(ck[3]),
    .clk_out_t1_e1(ck[4]), .clk_out_sonet(ck[5]),
    .frame_pulse_out_a(ck[6]), .frame_pulse_out_b(ck[7]),
    .frame_pulse_out_c(ck[8]), .frame_pulse_out_selectable(fs),
    .frame_pulse_out_sonet(ck[9]));
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rw(input logic [11:0] a, input logic wr,
                    input logic [31:0] d, m, x, input logic er);
    int k;
    k = 0;
    q.push_back('{x, m, er});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic win();
    repeat (4020) @(posedge core_clk);
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ******************
  // Result watchers
  // ******************
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      cmp(prdata & e.m, e.d);
      cmp({31'h0, pslverr}, {31'h0, e.e});
    end
    if (fs === 1'b1) w <= w + 1;
    else if (w > 0) begin
      if (fq.size() > 0) cmp(w, fq.pop_front());
      w <= 0;
    end
  end
  // Per frame: clock rises counted, pulse widths taken at the fall
  always @(posedge core_clk) begin
    fa_p <= ck[6];
    ck_p <= ck;
    for (int i = 0; i < 10; i++) begin
      nk[i] <= (ck[6] && !fa_p ? 0 : nk[i])
             + (i < 6 ? ck[i] && !ck_p[i] : ck[i]);
    end
    if (ck[6] && !fa_p) begin
      cmp(nk[0], 512);
      cmp(nk[1], 1024);
      cmp(nk[2], 2048);
      cmp(nk[3], 4096);
      cmp(nk[4] >= 192 && nk[4] <= 194, 1);
      cmp(nk[5] >= 2429 && nk[5] <= 2431, 1);
    end
    if (!ck[6] && fa_p) begin
      cmp(nk[6], 49);
      cmp(nk[7], 25);
      cmp(nk[8], 13);
      cmp(nk[9], 11);
    end
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rw(12'h00c, 1, 32'h0000_001f, 0, 0, 0);
    rw(12'h000, 0, 0, '1, 32'h0000_000c, 0);
    rw(12'h018, 0, 0, '1, 0, 1);
    rw(12'h014, 1, 0, 0, 0, 1);
    sd = $random(seed);
    rw(12'h008, 1, sd, 0, 0, 0);
    rw(12'h008, 0, 0, 32'h0000_0fff, sd & 32'h0000_0fff, 0);
    en <= 4'h3;
    win();
    fq.push_back(6);
    rw(12'h014, 0, 0, 32'h0000_0fff, 32'h0000_0023, 0);
    rw(12'h010, 0, 0, 32'h0000_0fff, 32'h0000_030c, 0);
    rw(12'h008, 1, 32'h0000_0024, 0, 0, 0);
    rw(12'h000, 1, 32'h0000_000e, 0, 0, 0);
    win();
    rw(12'h010, 0, 0, 32'h0000_0f03, 32'h0000_0201, 0);
    rw(12'h000, 1, 32'h0000_000c, 0, 0, 0);
    en <= 4'h2;
    win();
    rw(12'h010, 0, 0, 32'h0000_0fff, 32'h0000_0211, 0);
    en <= 4'h8;
    win();
    rw(12'h010, 0, 0, 32'h0000_0fff, 32'h0000_0813, 0);
    en <= 4'h0;
    win();
    rw(12'h010, 0, 0, 32'h0000_0020, 32'h0000_0020, 0);
    en <= 4'h1;
    win();
    rw(12'h010, 0, 0, 32'h0000_0f23, 32'h0000_0100, 0);
    en <= 4'h2;
    rw(12'h004, 1, 32'h0000_0007, 0, 0, 0);
    win();
    rw(12'h010, 0, 0, 32'h0000_0020, 32'h0000_0020, 0);
    rw(12'h004, 1, 32'h0000_0004, 0, 0, 0);
    win();
    rw(12'h010, 0, 0, 32'h0000_0023, 32'h0000_0001, 0);
    rw(12'h004, 1, 32'h0000_0001, 0, 0, 0);
    for (int m = 0; m < 3; m++) begin
      rw(12'h000, 1, {28'h0, m[1:0], 2'b00}, 0, 0, 0);
      win();
      rw(12'h010, 0, 0, 32'h0000_0060,
         {25'h0, m == 2, m == 1, 5'h0}, 0);
    end
    rw(12'h000, 1, 32'h0000_000d, 0, 0, 0);
    rw(12'h000, 0, 0, '1, 32'h0000_000d, 0);
    rw(12'h010, 0, 0, 32'h0000_0080, 32'h0000_0080, 0);
    h = 0;
    repeat (25100) begin
      @(posedge core_clk);
      h = h | {22'h0, ck};
    end
    cmp(h, 0);
    cmp(fq.size(), 0);
    complete_run();
  end
endmodule
